/* File: fault_defines.svh */
// Purpose: Offsets, fields, reset values and codes
// Assumes: 32-bit AHB-Lite word registers
// Notes: Header only, definitions only
`ifndef FAULT_DEFINES_SVH
`define FAULT_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define CTRL_EM_BIT 0
`define CTRL_TS_BIT 1
`define CTRL_MP_BIT 2
`define CTRL_RESET 3'h4
`define VEC_RANGE 8'h05
`define VEC_INVOP 8'h06
`define VEC_NODEV 8'h07
`define VEC_DOUBLE 8'h08
`define VEC_PAGE 8'h0E
`define OPC_RSV_A 8'hD6
`define OPC_RSV_B 8'hF1
`define ERR_DOUBLE 32'h00000000
`endif

/* File: fault_pkg.sv */
// Purpose: Types for the fault classifier
// Assumes: Retirement pipeline tags each instruction with a kind
// Notes: Codes are binary and fixed
package fault_pkg;
  typedef enum logic [3:0] {
    K_PLAIN = 4'h0,
    K_RANGE = 4'h1,
    K_BADOP = 4'h2,
    K_UNDEF = 4'h3,
    K_FARLD = 4'h4,
    K_SYSTBL = 4'h5,
    K_RESUME = 4'h6,
    K_FLOAT = 4'h7,
    K_FSYNC = 4'h8
  } instr_kind_e;
  typedef enum logic [1:0] {
    C_BENIGN = 2'h0,
    C_CONTRIB = 2'h1,
    C_PAGE = 2'h2
  } fault_class_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_CALL = 2'h1,
    S_DFCALL = 2'h2,
    S_SHUT = 2'h3
  } call_state_e;
endpackage

/* File: cpu_fault_classifier.sv */
// Purpose: Range, opcode and float faults plus double-fault escalation
// Assumes: Retire inputs and dispatch inputs on clk_sys; nmi and init pins async
// Notes: Requests leave one cycle after their cause
`include "fault_defines.svh"
module cpu_fault_classifier (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic retire_valid,
  input wire fault_pkg::instr_kind_e retire_kind,
  input wire logic [7:0] retire_opcode,
  input wire logic [31:0] bound_index,
  input wire logic [31:0] bound_lower,
  input wire logic [31:0] bound_upper,
  input wire logic src_is_mem,
  input wire logic dest_is_mem,
  input wire logic lock_prefix,
  input wire logic lockable,
  input wire logic real_or_v86,
  input wire logic in_mgmt_mode,
  output logic retire_cancel,
  input wire logic exc_in_valid,
  input wire logic [7:0] exc_in_vector,
  input wire logic exc_in_maskable,
  input wire logic exc_in_prefetch,
  input wire logic call_done,
  input wire logic nmi_active,
  input wire logic nmi_pin,
  input wire logic init_pin,
  output logic exc_req,
  output logic [7:0] exc_vector,
  output logic exc_err_valid,
  output logic [31:0] exc_err_code,
  output logic exc_ip_undefined,
  output logic shutdown,
  output logic shutdown_cycle
);
  import fault_pkg::*;

  // ----------------------------------------
  // Class lookup
  // ----------------------------------------
  function automatic fault_class_e class_of(input logic [7:0] v, input logic maskable);
    fault_class_e c;
    c = C_BENIGN;
    if (!maskable) begin
      if (v == 8'h00 || (v >= 8'h0A && v <= 8'h0D)) begin
        c = C_CONTRIB;
      end else if (v == `VEC_PAGE) begin
        c = C_PAGE;
      end
    end
    return c;
  endfunction

  function automatic logic makes_double(input fault_class_e first, input fault_class_e second);
    return (second == C_CONTRIB && first != C_BENIGN) ||
           (second == C_PAGE && first == C_PAGE);
  endfunction

  // ----------------------------------------
  // Control register and bus
  // ----------------------------------------
  logic [2:0] ctrl_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic flag_em;
  logic flag_ts;
  logic flag_mp;
  call_state_e state_q;
  call_state_e state_d;
  fault_class_e first_q;
  fault_class_e first_d;
  logic nmi_lock_q;
  logic [7:0] last_vec_q;

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign flag_em = ctrl_q[`CTRL_EM_BIT];
  assign flag_ts = ctrl_q[`CTRL_TS_BIT];
  assign flag_mp = ctrl_q[`CTRL_MP_BIT];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_pend_q && wr_addr_q == `OFS_CTRL) begin
      ctrl_q <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `OFS_CTRL: begin
          hrdata_q <= {29'h00000000, ctrl_q};
        end
        `OFS_STAT: begin
          hrdata_q <= {16'h0000, last_vec_q, 2'h0, nmi_lock_q, first_q, state_q, (state_q == S_SHUT)};
        end
        default: begin
          hrdata_q <= 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] nmi_sync_q;
  logic [1:0] init_sync_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_sync_q <= 2'h0;
      init_sync_q <= 2'h0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[0], nmi_pin};
      init_sync_q <= {init_sync_q[0], init_pin};
    end
  end

  // ----------------------------------------
  // Retire-time detection
  // ----------------------------------------
  logic range_hit;
  logic invop_hit;
  logic nodev_hit;
  logic local_v;
  logic [7:0] local_vec;

  always_comb begin
    range_hit = retire_valid && retire_kind == K_RANGE &&
                ($signed(bound_index) < $signed(bound_lower) ||
                 $signed(bound_index) > $signed(bound_upper));
    invop_hit = retire_valid && (
                (retire_kind == K_BADOP && retire_opcode != `OPC_RSV_A &&
                 retire_opcode != `OPC_RSV_B) ||
                retire_kind == K_UNDEF ||
                (retire_kind == K_FARLD && !src_is_mem) ||
                (lock_prefix && (!lockable || !dest_is_mem)) ||
                (retire_kind == K_SYSTBL && real_or_v86) ||
                (retire_kind == K_RESUME && !in_mgmt_mode));
    nodev_hit = retire_valid && (
                (retire_kind == K_FLOAT && (flag_em || flag_ts)) ||
                (retire_kind == K_FSYNC && flag_mp && flag_ts));
    local_v = range_hit || invop_hit || nodev_hit;
    if (invop_hit) begin
      local_vec = `VEC_INVOP;
    end else if (nodev_hit) begin
      local_vec = `VEC_NODEV;
    end else begin
      local_vec = `VEC_RANGE;
    end
  end

  // Faulting instruction does not commit, so it restarts intact
  assign retire_cancel = local_v;

  // ----------------------------------------
  // Candidate exception
  // ----------------------------------------
  logic cand_v;
  logic [7:0] cand_vec;
  fault_class_e cand_cls;
  logic cand_pref;
  always_comb begin
    cand_v = exc_in_valid || local_v;
    cand_vec = exc_in_valid ? exc_in_vector : local_vec;
    cand_pref = exc_in_valid && exc_in_prefetch;
    cand_cls = exc_in_valid ? class_of(exc_in_vector, exc_in_maskable) : C_BENIGN;
  end

  // ----------------------------------------
  // Handler-call tracking
  // ----------------------------------------
  logic req_d;
  logic [7:0] vec_d;
  logic dbl_d;
  logic enter_shut;
  always_comb begin
    state_d = state_q;
    first_d = first_q;
    req_d = 1'b0;
    vec_d = cand_vec;
    dbl_d = 1'b0;
    enter_shut = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (cand_v) begin
          req_d = 1'b1;
          first_d = cand_cls;
          state_d = S_CALL;
        end
      end
      S_CALL: begin
        if (cand_v && !call_done && !cand_pref && makes_double(first_q, cand_cls)) begin
          req_d = 1'b1;
          dbl_d = 1'b1;
          vec_d = `VEC_DOUBLE;
          state_d = S_DFCALL;
        end else if (cand_v) begin
          req_d = 1'b1;
          first_d = cand_cls;
        end else if (call_done) begin
          state_d = S_IDLE;
        end
      end
      S_DFCALL: begin
        if (cand_v && !call_done) begin
          enter_shut = 1'b1;
          state_d = S_SHUT;
        end else if (cand_v) begin
          req_d = 1'b1;
          first_d = cand_cls;
          state_d = S_CALL;
        end else if (call_done) begin
          state_d = S_IDLE;
        end
      end
      S_SHUT: begin
        if (!nmi_lock_q && (init_sync_q[1] || nmi_sync_q[1])) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      first_q <= C_BENIGN;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_lock_q <= 1'b0;
    end else if (enter_shut) begin
      nmi_lock_q <= nmi_active;
    end
  end

  // ----------------------------------------
  // Request outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      exc_req <= 1'b0;
      exc_vector <= 8'h00;
      exc_err_valid <= 1'b0;
      exc_err_code <= 32'h00000000;
      exc_ip_undefined <= 1'b0;
      last_vec_q <= 8'h00;
    end else begin
      exc_req <= req_d;
      exc_vector <= req_d ? vec_d : 8'h00;
      exc_err_valid <= req_d && dbl_d;
      exc_err_code <= `ERR_DOUBLE;
      exc_ip_undefined <= req_d && dbl_d;
      if (req_d) begin
        last_vec_q <= vec_d;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shutdown <= 1'b0;
      shutdown_cycle <= 1'b0;
    end else begin
      shutdown <= (state_d == S_SHUT);
      shutdown_cycle <= enter_shut;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence range_fault_s;
    retire_valid && !exc_in_valid && state_q == S_IDLE && range_hit && !invop_hit && !nodev_hit;
  endsequence

  range_vector_a: assert property (range_fault_s |=> exc_req && exc_vector == 8'h05 && !exc_err_valid)
    else $error("range fault did not raise vector 5");

  reserved_opcode_a: assert property (retire_valid && retire_kind == K_BADOP &&
    (retire_opcode == 8'hD6 || retire_opcode == 8'hF1) && !lock_prefix |-> !invop_hit)
    else $error("reserved opcode faulted");

  sync_wait_a: assert property (retire_valid && retire_kind == K_FSYNC && !(flag_mp && flag_ts) |-> !nodev_hit)
    else $error("sync instruction faulted without both flags");

  retire_gate_a: assert property (!retire_valid |-> !retire_cancel)
    else $error("fault raised without retire");

  double_code_a: assert property (exc_req && exc_vector == 8'h08 |-> exc_err_valid && exc_err_code == 32'h0 &&
    exc_ip_undefined)
    else $error("double fault code wrong");

  sequence contrib_first_s;
    state_q == S_CALL && first_q == C_CONTRIB && !call_done;
  endsequence

  double_matrix_a: assert property (contrib_first_s ##0 (exc_in_valid && !exc_in_prefetch && !exc_in_maskable &&
    (exc_in_vector == 8'h00 || (exc_in_vector >= 8'h0A && exc_in_vector <= 8'h0D))) |=>
    exc_req && exc_vector == 8'h08 && state_q == S_DFCALL)
    else $error("contributory pair missed double fault");

  prefetch_skip_a: assert property (state_q == S_CALL && exc_in_valid && exc_in_prefetch |=> exc_vector != 8'h08)
    else $error("prefetch fault escalated");

  shut_cycle_a: assert property ($rose(shutdown) |-> shutdown_cycle ##1 !shutdown_cycle)
    else $error("shutdown cycle not single pulse");

  nmi_lock_a: assert property (state_q == S_SHUT && nmi_lock_q |=> shutdown)
    else $error("left shutdown despite nmi lock");

  lock_capture_a: assert property (enter_shut |=> nmi_lock_q == $past(nmi_active))
    else $error("nmi lock not captured on shutdown entry");

  sequence dfcall_hit_s;
    state_q == S_DFCALL && exc_in_valid && !call_done;
  endsequence

  shut_entry_a: assert property (dfcall_hit_s |=> shutdown && shutdown_cycle && !exc_req)
    else $error("exception in double-fault call did not shut down");

  shut_quiet_a: assert property (shutdown |-> !exc_req)
    else $error("request issued during shutdown");

  shut_exit_a: assert property (state_q == S_SHUT && !nmi_lock_q && init_sync_q[1] |=> !shutdown)
    else $error("init did not end shutdown");

  invop_vector_a: assert property (retire_valid && !exc_in_valid && state_q == S_IDLE &&
    invop_hit |=> exc_req && exc_vector == 8'h06 && !exc_err_valid)
    else $error("invalid opcode did not raise vector 6");

  nodev_vector_a: assert property (retire_valid && !exc_in_valid && state_q == S_IDLE &&
    nodev_hit && !invop_hit |=> exc_req && exc_vector == 8'h07 && !exc_err_valid)
    else $error("float fault did not raise vector 7");

endmodule // cpu_fault_classifier

/* File: dispatch_model.sv */
// Purpose: Dispatch side model that closes handler calls
// Assumes: One handler call for each exc_req pulse
// Notes: done_en low holds the call open
module dispatch_model #(
  parameter int DELAY = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic exc_req,
  input wire logic done_en,
  output logic call_done
);
  int cnt_q;
  // ----------------
  // Call completion
  // ----------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      call_done <= 1'b0;
    end else begin
      call_done <= done_en && cnt_q == 1;
      if (exc_req) begin
        cnt_q <= DELAY;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule // dispatch_model

/* File: tb_cpu_fault_classifier.sv */
// Purpose: Self-checking bench for the fault classifier
// Assumes: Zero-wait word-only bus slave
// Notes: Dispatch model closes calls unless held open
`include "fault_defines.svh"
module tb_cpu_fault_classifier;
  timeunit 1ns;
  timeprecision 100ps;
  import fault_pkg::*;
  logic clk_sys, rst, hsel, hwrite, hresp, hreadyout, retire_valid, retire_cancel, done_en, call_done;
  logic [31:0] haddr, hwdata, hrdata, bound_index, bound_lower, bound_upper, exc_err_code;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] retire_opcode, exc_in_vector, exc_vector;
  logic src_is_mem, dest_is_mem, lock_prefix, lockable, real_or_v86, in_mgmt_mode;
  logic exc_in_valid, exc_in_maskable, exc_in_prefetch, nmi_active, nmi_pin, init_pin;
  logic exc_req, exc_err_valid, exc_ip_undefined, shutdown, shutdown_cycle;
  wire hready;
  instr_kind_e retire_kind;
  int err_count, num_checks;
  assign hready = hreadyout;
  cpu_fault_classifier cpu_fault_classifier_inst (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .retire_valid, .retire_kind, .retire_opcode, .bound_index,
    .bound_lower, .bound_upper, .src_is_mem, .dest_is_mem, .lock_prefix, .lockable, .real_or_v86,
    .in_mgmt_mode, .retire_cancel, .exc_in_valid, .exc_in_vector, .exc_in_maskable, .exc_in_prefetch,
    .call_done, .nmi_active, .nmi_pin, .init_pin, .exc_req, .exc_vector, .exc_err_valid, .exc_err_code,
    .exc_ip_undefined, .shutdown, .shutdown_cycle);
  dispatch_model dispatch_model_inst (.clk_sys, .rst, .exc_req, .done_en, .call_done);
  always #12.5 clk_sys = ~clk_sys;
  // ----------------
  // Checks and end
  // ----------------
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // ----------------
  // Bus access
  // ----------------
  task automatic wait_ready;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic rd(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    chk(hresp, 0);
    if (!wr) begin
      chk(hrdata & m, d);
    end
  endtask
  // ----------------
  // Retire and dispatch
  // ----------------
  task automatic res(input logic [7:0] ev, input logic ee);
    chk(exc_req, ev != 0);
    chk(exc_vector, ev);
    chk(exc_err_valid, ee);
    chk(exc_ip_undefined, ee);
    chk(exc_err_code, 0);
  endtask
  task automatic retire(input instr_kind_e k, input logic [7:0] opc, input logic [31:0] idx,
                        input logic [6:0] f, input logic [7:0] ev);
    @(posedge clk_sys);
    retire_kind <= k;
    retire_opcode <= opc;
    bound_index <= idx;
    {retire_valid, src_is_mem, dest_is_mem, lock_prefix, lockable, real_or_v86, in_mgmt_mode} <= f;
    #1;
    chk(retire_cancel, ev != 0);
    @(posedge clk_sys);
    retire_valid <= 1'b0;
    #1;
    res(ev, 0);
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic exc(input logic [7:0] v, input logic [1:0] mp);
    @(posedge clk_sys);
    exc_in_valid <= 1'b1;
    exc_in_vector <= v;
    {exc_in_maskable, exc_in_prefetch} <= mp;
    @(posedge clk_sys);
    exc_in_valid <= 1'b0;
    #1;
  endtask
  task automatic shut;
    chk(shutdown, 1);
    chk(shutdown_cycle, 1);
    @(posedge clk_sys);
    #1;
    chk(shutdown_cycle, 0);
    chk(shutdown, 1);
  endtask
  task automatic leave(input logic [1:0] pins, input logic ex);
    int i;
    @(posedge clk_sys);
    {nmi_pin, init_pin} <= pins;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      if (shutdown === 1'b0) break;
    end
    chk(shutdown, !ex);
    @(posedge clk_sys);
    {nmi_pin, init_pin} <= 2'h0;
  endtask
  task automatic reset;
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(hreadyout, 1);
    chk(shutdown, 0);
    chk(exc_req, 0);
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {clk_sys, hsel, hwrite, retire_valid, exc_in_valid, exc_in_maskable, exc_in_prefetch} = '0;
    {src_is_mem, dest_is_mem, lock_prefix, lockable, real_or_v86, in_mgmt_mode} = '0;
    {nmi_active, nmi_pin, init_pin, haddr, hwdata, htrans, retire_opcode, exc_in_vector} = '0;
    {rst, done_en, hsize, bound_index, err_count, num_checks} = {2'h3, 3'h2, 32'h0, 32'h0, 32'h0};
    bound_lower = 32'hFFFFFFFE;
    bound_upper = 32'h0000000A;
    retire_kind = K_PLAIN;
    reset();
    rd(0, `OFS_CTRL, 32'h4, 32'hFFFFFFFF);
    rd(0, `OFS_STAT, 32'h0, 32'h1F);
    rd(0, 32'h40, 32'h0, 32'hFFFFFFFF);
    retire(K_RANGE, 8'h62, 32'hFFFFFFFB, 7'h70, `VEC_RANGE);
    retire(K_RANGE, 8'h62, 32'hFFFFFFFB, 7'h70, `VEC_RANGE);
    retire(K_RANGE, 8'h62, 32'h80000000, 7'h70, `VEC_RANGE);
    retire(K_RANGE, 8'h62, 32'h0000000B, 7'h70, `VEC_RANGE);
    retire(K_RANGE, 8'h62, 32'hFFFFFFFE, 7'h70, 0);
    retire(K_RANGE, 8'h62, 32'h0000000A, 7'h70, 0);
    retire(K_BADOP, 8'h0F, 0, 7'h70, `VEC_INVOP);
    retire(K_BADOP, `OPC_RSV_A, 0, 7'h70, 0);
    retire(K_BADOP, `OPC_RSV_B, 0, 7'h70, 0);
    retire(K_UNDEF, 8'h0B, 0, 7'h70, `VEC_INVOP);
    retire(K_UNDEF, 8'h0B, 0, 7'h30, 0);
    retire(K_FARLD, 8'hC4, 0, 7'h50, `VEC_INVOP);
    retire(K_FARLD, 8'hC4, 0, 7'h70, 0);
    retire(K_PLAIN, 8'h01, 0, 7'h78, `VEC_INVOP);
    retire(K_PLAIN, 8'h01, 0, 7'h6C, `VEC_INVOP);
    retire(K_PLAIN, 8'h01, 0, 7'h7C, 0);
    retire(K_SYSTBL, 8'h00, 0, 7'h72, `VEC_INVOP);
    retire(K_SYSTBL, 8'h00, 0, 7'h70, 0);
    retire(K_RESUME, 8'hAA, 0, 7'h70, `VEC_INVOP);
    retire(K_RESUME, 8'hAA, 0, 7'h71, 0);
    for (int c = 0; c < 8; c++) begin
      rd(1, `OFS_CTRL, c, 0);
      retire(K_FLOAT, 8'hD8, 0, 7'h70, (c[0] | c[1]) ? `VEC_NODEV : 8'h00);
      retire(K_FSYNC, 8'h9B, 0, 7'h70, (c[2] & c[1]) ? `VEC_NODEV : 8'h00);
    end
    rd(1, `OFS_CTRL, 32'h4, 0);
    rd(0, `OFS_STAT, 32'h00000700, 32'h0000FF1F);
    @(posedge clk_sys);
    done_en <= 1'b0;
    reset();
    exc(13, 0);
    res(13, 0);
    exc(14, 0);
    res(14, 0);
    exc(14, 0);
    res(`VEC_DOUBLE, 1);
    exc(1, 0);
    shut();
    rd(0, `OFS_STAT, 32'h00000817, 32'h0000FF3F);
    leave(2'h2, 1);
    reset();
    exc(32, 2'h2);
    res(32, 0);
    exc(13, 0);
    res(13, 0);
    exc(13, 2'h1);
    res(13, 0);
    exc(12, 0);
    res(`VEC_DOUBLE, 1);
    @(posedge clk_sys);
    nmi_active <= 1'b1;
    exc(0, 0);
    shut();
    leave(2'h2, 0);
    leave(2'h1, 0);
    nmi_active <= 1'b0;
    reset();
    exc(13, 0);
    res(13, 0);
    exc(5, 0);
    res(5, 0);
    exc(14, 0);
    res(14, 0);
    exc(13, 0);
    res(`VEC_DOUBLE, 1);
    exc(2, 0);
    shut();
    leave(2'h1, 1);
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end
endmodule // tb_cpu_fault_classifier
